// File: rtl/lrd_pkg.sv
// Shared constants for the receive output and drive monitor channel
package lrd_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS      = 4'h0;
  localparam logic [3:0] STATUS_OFS    = 4'h4;
  localparam logic [3:0] INT_STAT_OFS  = 4'h8;
  localparam logic [3:0] INT_MASK_OFS  = 4'hc;
  // Control field positions
  localparam int CTRL_SINGLE_RAIL  = 0;
  localparam int CTRL_DECODE_EN    = 1;
  localparam int CTRL_E3_CODE      = 2;
  localparam int CTRL_INT_MONITOR  = 3;
  localparam int CTRL_MUTE_ON_LOS  = 4;
  localparam int CTRL_W            = 5;
  localparam logic [4:0] CTRL_RESET = 5'h02;
  // Status and interrupt field positions
  localparam int EV_LOS    = 0;
  localparam int EV_LOL    = 1;
  localparam int EV_FAULT  = 2;
  localparam int EV_VIOL   = 3;
  localparam int EV_W      = 4;
  localparam logic [3:0] MASK_RESET = 4'h0;
  // Synchroniser lanes
  localparam int S_RCLK  = 0;
  localparam int S_RPOS  = 1;
  localparam int S_RNEG  = 2;
  localparam int S_TCLK  = 3;
  localparam int S_MONP  = 4;
  localparam int S_MONN  = 5;
  localparam int S_TXP   = 6;
  localparam int S_TXN   = 7;
  localparam int S_REF   = 8;
  localparam int S_W     = 9;
  // Drive monitor quiet limit, in transmit bit periods
  localparam logic [7:0] MON_QUIET_BITS = 8'h80;
  // Zero run that declares signal loss, in recovered bit periods
  localparam logic [7:0] LOS_ZERO_BITS  = 8'haf;
  // Zero runs that count as excessive for each line code
  localparam logic [7:0] EXZ_B3ZS_BITS  = 8'h03;
  localparam logic [7:0] EXZ_HDB3_BITS  = 8'h04;
  // Lock check: window in reference edges, deviation in tenths of a percent
  localparam int LOL_WINDOW  = 1000;
  localparam int LOL_TENTHS  = 5;
  localparam logic [10:0] LOL_WIN_CNT = 11'(LOL_WINDOW);
  localparam logic [10:0] LOL_TOL_CNT = 11'(LOL_WINDOW * LOL_TENTHS / 1000);
endpackage

// File: rtl/lrd_channel.sv
// One channel of receive output logic, lock and signal checks, and drive monitor
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lrd_channel
(
  input  wire logic        MCLK,                        // System clock, 25 MHz
  input  wire logic        RSTN,                        // Synchronous reset, active low
  input  wire logic        WB_CYC_I,                    // Wishbone cycle
  input  wire logic        WB_STB_I,                    // Wishbone strobe
  input  wire logic        WB_WE_I,                     // Wishbone write enable
  input  wire logic [3:0]  WB_ADR_I,                    // Wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,                    // Wishbone byte selects
  input  wire logic [31:0] WB_DAT_I,                    // Wishbone write data
  output logic [31:0]      WB_DAT_O,                    // Wishbone read data
  output logic             WB_ACK_O,                    // Wishbone acknowledge
  input  wire logic        LINE_IN_PLUS,                // Sliced positive line pulse
  input  wire logic        LINE_IN_MINUS,               // Sliced negative line pulse
  input  wire logic        RCLK_IN,                     // Clock from data recovery
  input  wire logic        REF_CLK_IN,                  // Channel rate reference clock
  input  wire logic        TX_CLK_IN,                   // Transmit bit clock
  input  wire logic        LINE_OUT_PLUS,               // Internal drive, positive
  input  wire logic        LINE_OUT_MINUS,              // Internal drive, negative
  input  wire logic        MONITOR_PLUS_IN,             // External monitor, positive
  input  wire logic        MONITOR_MINUS_IN,            // External monitor, negative
  output logic             RX_PLUS_RAIL,                // Plus rail or serial data
  output logic             RX_MINUS_RAIL_OR_VIOLATION,  // Minus rail or violation strobe
  output logic             RECOVERED_CLOCK_OUT,         // Recovered clock to framer
  output logic             DRIVE_FAULT_FLAG,            // No transmit activity
  output logic             SIGNAL_LOST_FLAG,            // Loss of signal
  output logic             CLOCK_UNLOCKED_FLAG,         // Loss of lock
  output logic             IRQ                          // Level interrupt, active high
);

  // Two-stage synchronisers for every pin from outside MCLK
  logic [lrd_pkg::S_W-1:0] meta_r;
  logic [lrd_pkg::S_W-1:0] sync_r;
  logic [lrd_pkg::S_W-1:0] prev_r;
  always_ff @(posedge MCLK)
  begin
    meta_r <= {REF_CLK_IN, LINE_OUT_MINUS, LINE_OUT_PLUS, MONITOR_MINUS_IN, MONITOR_PLUS_IN,
               TX_CLK_IN, LINE_IN_MINUS, LINE_IN_PLUS, RCLK_IN};
    sync_r <= meta_r;
    prev_r <= sync_r;
  end

  // Edge strobes on the synchronised clocks
  logic rclk_rise;
  logic tclk_rise;
  logic ref_rise;
  assign rclk_rise = sync_r[lrd_pkg::S_RCLK] & ~prev_r[lrd_pkg::S_RCLK];
  assign tclk_rise = sync_r[lrd_pkg::S_TCLK] & ~prev_r[lrd_pkg::S_TCLK];
  assign ref_rise  = sync_r[lrd_pkg::S_REF]  & ~prev_r[lrd_pkg::S_REF];

  // Software registers
  logic [lrd_pkg::CTRL_W-1:0] ctrl_r;
  logic [lrd_pkg::EV_W-1:0]   int_stat_r;
  logic [lrd_pkg::EV_W-1:0]   int_mask_r;
  logic single_rail;
  logic dec_en;
  logic e3_code;
  logic int_mon;
  logic mute_en;
  assign single_rail = ctrl_r[lrd_pkg::CTRL_SINGLE_RAIL];
  assign dec_en      = ctrl_r[lrd_pkg::CTRL_DECODE_EN];
  assign e3_code     = ctrl_r[lrd_pkg::CTRL_E3_CODE];
  assign int_mon     = ctrl_r[lrd_pkg::CTRL_INT_MONITOR];
  assign mute_en     = ctrl_r[lrd_pkg::CTRL_MUTE_ON_LOS];

  // Drive monitor source select; external pins unused when internal
  logic mon_pulse;
  assign mon_pulse = int_mon ? (sync_r[lrd_pkg::S_TXP] | sync_r[lrd_pkg::S_TXN])
                             : (sync_r[lrd_pkg::S_MONP] | sync_r[lrd_pkg::S_MONN]);

  // Quiet counter on transmit bit edges, saturating at the limit
  logic [7:0] mon_cnt_r;
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      mon_cnt_r <= 8'h00;
    else if (tclk_rise && mon_pulse)
      mon_cnt_r <= 8'h00;
    else if (tclk_rise && mon_cnt_r != lrd_pkg::MON_QUIET_BITS)
      mon_cnt_r <= mon_cnt_r + 8'h01;
  end

  // Fault flag: high only after a full quiet window
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      DRIVE_FAULT_FLAG <= 1'b0;
    else
      DRIVE_FAULT_FLAG <= (mon_cnt_r == lrd_pkg::MON_QUIET_BITS);
  end

  // Receive line bits, taken when the recovered clock rises
  logic in_p;
  logic in_n;
  logic in_pulse;
  assign in_p     = sync_r[lrd_pkg::S_RPOS];
  assign in_n     = sync_r[lrd_pkg::S_RNEG];
  assign in_pulse = in_p | in_n;

  // Zero run length, shared by loss of signal and excessive zeros
  logic [7:0] zrun_r;
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      zrun_r <= 8'h00;
    else if (rclk_rise && in_pulse)
      zrun_r <= 8'h00;
    else if (rclk_rise && zrun_r != 8'hff)
      zrun_r <= zrun_r + 8'h01;
  end

  // Loss of signal follows the zero run; a pulse clears it at once
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      SIGNAL_LOST_FLAG <= 1'b0;
    else if (rclk_rise)
      SIGNAL_LOST_FLAG <= !in_pulse && (zrun_r >= lrd_pkg::LOS_ZERO_BITS - 8'h01);
  end

  // Bipolar violation tracking against the last pulse polarity
  logic last_pol_r;
  logic seen_r;
  logic is_viol;
  assign is_viol = in_pulse && seen_r && (in_p == last_pol_r);
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      last_pol_r <= 1'b0;
      seen_r     <= 1'b0;
    end
    else if (rclk_rise && in_pulse)
    begin
      last_pol_r <= in_p;
      seen_r     <= 1'b1;
    end
  end

  // Substitution recognition; anything else is a code violation
  logic [3:0] dly_r;
  logic       is_sub;
  logic       code_violation;
  logic       excess_zeros_event;
  logic [3:0] dly_nxt;
  assign is_sub = dec_en && is_viol && (e3_code ? (dly_r[1:0] == 2'b00) : !dly_r[0]);
  assign code_violation = is_viol && !is_sub;
  assign excess_zeros_event = !in_pulse &&
    (zrun_r + 8'h01 == (e3_code ? lrd_pkg::EXZ_HDB3_BITS : lrd_pkg::EXZ_B3ZS_BITS));
  always_comb
  begin
    dly_nxt = {dly_r[2:0], in_pulse};
    if (is_sub && e3_code)
      dly_nxt = 4'h0;
    else if (is_sub)
      dly_nxt[2:0] = 3'h0;
  end

  // Decoder delay line; the oldest stage is the decoded bit
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      dly_r <= 4'h0;
    else if (rclk_rise)
      dly_r <= dly_nxt;
  end

  // Rail outputs and recovered clock share one update edge
  logic mute;
  logic plus_nxt;
  logic minus_nxt;
  assign mute = mute_en && SIGNAL_LOST_FLAG;
  always_comb
  begin
    if (mute)
    begin
      plus_nxt  = 1'b0;
      minus_nxt = 1'b0;
    end
    else if (single_rail)
    begin
      plus_nxt  = dec_en ? dly_r[3] : in_pulse;
      minus_nxt = code_violation || excess_zeros_event;
    end
    else
    begin
      plus_nxt  = in_p;
      minus_nxt = in_n;
    end
  end

  // Rails move only with the rising recovered clock
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      RX_PLUS_RAIL               <= 1'b0;
      RX_MINUS_RAIL_OR_VIOLATION <= 1'b0;
    end
    else if (rclk_rise)
    begin
      RX_PLUS_RAIL               <= plus_nxt;
      RX_MINUS_RAIL_OR_VIOLATION <= minus_nxt;
    end
  end

  // Recovered clock out, delayed like the data so edges stay aligned
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      RECOVERED_CLOCK_OUT <= 1'b0;
    else
      RECOVERED_CLOCK_OUT <= sync_r[lrd_pkg::S_RCLK];
  end

  // Lock check: count recovered edges across a window of reference edges
  logic [10:0] ref_cnt_r;
  logic [10:0] rec_cnt_r;
  logic        win_end;
  logic [10:0] rec_now;
  assign win_end = ref_rise && (ref_cnt_r == lrd_pkg::LOL_WIN_CNT - 11'h001);
  assign rec_now = rec_cnt_r + {10'h000, rclk_rise};
  always_ff @(posedge MCLK)
  begin
    if (!RSTN || win_end)
    begin
      ref_cnt_r <= 11'h000;
      rec_cnt_r <= 11'h000;
    end
    else
    begin
      ref_cnt_r <= ref_cnt_r + {10'h000, ref_rise};
      if (rec_cnt_r != 11'h7ff)
        rec_cnt_r <= rec_now;
    end
  end

  // Deviation of 0.5% or more over the window declares loss of lock
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      CLOCK_UNLOCKED_FLAG <= 1'b0;
    else if (win_end)
      CLOCK_UNLOCKED_FLAG <=
        (rec_now >= lrd_pkg::LOL_WIN_CNT + lrd_pkg::LOL_TOL_CNT) ||
        (rec_now <= lrd_pkg::LOL_WIN_CNT - lrd_pkg::LOL_TOL_CNT);
  end

  // Event strobes from flag rises and violation strobes
  logic [lrd_pkg::EV_W-1:0] flag_d_r;
  logic [lrd_pkg::EV_W-1:0] events;
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      flag_d_r <= '0;
    else
      flag_d_r <= {1'b0, DRIVE_FAULT_FLAG, CLOCK_UNLOCKED_FLAG, SIGNAL_LOST_FLAG};
  end
  assign events = {rclk_rise && single_rail && (code_violation || excess_zeros_event),
                   DRIVE_FAULT_FLAG & ~flag_d_r[lrd_pkg::EV_FAULT],
                   CLOCK_UNLOCKED_FLAG & ~flag_d_r[lrd_pkg::EV_LOL],
                   SIGNAL_LOST_FLAG & ~flag_d_r[lrd_pkg::EV_LOS]};

  // Wishbone slave: one wait state, writes land at the ack edge, unmapped reads return zero
  logic wb_req;
  logic wb_wr;
  logic wb_rd_stat;
  assign wb_req     = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr      = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0];
  assign wb_rd_stat = WB_ACK_O && !WB_WE_I && (WB_ADR_I == lrd_pkg::INT_STAT_OFS);
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= wb_req;
  end

  // Read data registered at the request edge
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      WB_DAT_O <= 32'h0000_0000;
    else if (wb_req && !WB_WE_I)
      unique case (WB_ADR_I)
        lrd_pkg::CTRL_OFS:     WB_DAT_O <= {27'h0, ctrl_r};
        lrd_pkg::STATUS_OFS:   WB_DAT_O <= {28'h0, 1'b0, DRIVE_FAULT_FLAG,
                                            CLOCK_UNLOCKED_FLAG, SIGNAL_LOST_FLAG};
        lrd_pkg::INT_STAT_OFS: WB_DAT_O <= {28'h0, int_stat_r};
        lrd_pkg::INT_MASK_OFS: WB_DAT_O <= {28'h0, int_mask_r};
        default:               WB_DAT_O <= 32'h0000_0000;
      endcase
  end

  // Control and mask writes, low byte lane only
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      ctrl_r     <= lrd_pkg::CTRL_RESET;
      int_mask_r <= lrd_pkg::MASK_RESET;
    end
    else if (wb_wr && WB_ADR_I == lrd_pkg::CTRL_OFS)
      ctrl_r <= WB_DAT_I[lrd_pkg::CTRL_W-1:0];
    else if (wb_wr && WB_ADR_I == lrd_pkg::INT_MASK_OFS)
      int_mask_r <= WB_DAT_I[lrd_pkg::EV_W-1:0];
  end

  // Sticky status; a read clears only the bits it returned, so an event
  // landing between the data edge and the ack edge is not lost; a new event wins
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      int_stat_r <= '0;
    else
      int_stat_r <= (wb_rd_stat ? (int_stat_r & ~WB_DAT_O[lrd_pkg::EV_W-1:0]) : int_stat_r)
                    | events;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      IRQ <= 1'b0;
    else
      IRQ <= |(int_stat_r & int_mask_r);
  end

  // Checks on the channel behaviour
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  chk_fault_after_quiet: assert property (
    tclk_rise && !mon_pulse && mon_cnt_r == 8'h7f |=> ##1 DRIVE_FAULT_FLAG)
    else $error("fault flag missing after quiet window");
  chk_fault_clear_pulse: assert property (
    tclk_rise && mon_pulse |=> ##1 !DRIVE_FAULT_FLAG)
    else $error("fault flag high after a transmit pulse");
  chk_monitor_source: assert property (
    int_mon && tclk_rise && (sync_r[lrd_pkg::S_TXP] || sync_r[lrd_pkg::S_TXN])
    |=> mon_cnt_r == 8'h00)
    else $error("internal drive pulse not seen by monitor");
  chk_los_clears: assert property (
    rclk_rise && in_pulse |=> !SIGNAL_LOST_FLAG)
    else $error("signal lost flag held through a pulse");
  chk_lol_declare: assert property (
    win_end && rec_now <= lrd_pkg::LOL_WIN_CNT - lrd_pkg::LOL_TOL_CNT |=> CLOCK_UNLOCKED_FLAG)
    else $error("slow recovered clock not flagged");
  chk_dual_plus_pulse: assert property (
    rclk_rise && !single_rail && in_p && !mute |=> RX_PLUS_RAIL)
    else $error("plus rail missed a positive pulse");
  chk_dual_minus_pulse: assert property (
    rclk_rise && !single_rail && in_n && !mute |=> RX_MINUS_RAIL_OR_VIOLATION)
    else $error("minus rail missed a negative pulse");
  chk_viol_strobe: assert property (
    rclk_rise && single_rail && !mute && code_violation |=> RX_MINUS_RAIL_OR_VIOLATION)
    else $error("violation strobe missing");
  chk_rail_on_edge: assert property (
    $changed(RX_PLUS_RAIL) || $changed(RX_MINUS_RAIL_OR_VIOLATION)
    |-> $rose(RECOVERED_CLOCK_OUT))
    else $error("rail changed away from recovered clock edge");
  chk_mute_rails: assert property (
    rclk_rise && mute |=> !RX_PLUS_RAIL && !RX_MINUS_RAIL_OR_VIOLATION)
    else $error("rails not muted during signal loss");

  cov_drive_fault: cover property ($rose(DRIVE_FAULT_FLAG));
  cov_lock_lost:   cover property ($rose(CLOCK_UNLOCKED_FLAG));
  cov_sub_decoded: cover property (rclk_rise && is_sub);
  cov_irq_raised:  cover property ($rose(IRQ));

endmodule
`default_nettype wire

// File: test/lrd_framer_model.sv
// Framer-side model that takes the receive rails at each recovered clock rise
`timescale 1ns/1ps
`default_nettype none
module lrd_framer_model
(
  input  wire logic mclk,       // System clock
  input  wire logic rstn,       // Synchronous reset, active low
  input  wire logic rclk_out,   // Recovered clock from the block
  input  wire logic plus_rail,  // Plus rail or serial data
  input  wire logic minus_rail, // Minus rail or violation strobe
  output int        plus_cnt,   // Ones taken from the plus rail
  output int        minus_cnt,  // Ones taken from the minus rail
  output int        rise_cnt,   // Recovered clock rises seen
  output int        skew_cnt    // Rail moves away from a clock rise
);
  logic       rclk_q;
  logic [1:0] rails_q;

  // Take rails once per rise; any move between rises would break a real framer's setup
  always_ff @(posedge mclk)
  begin
    rclk_q  <= rclk_out;
    rails_q <= {plus_rail, minus_rail};
    if (!rstn)
    begin
      plus_cnt  <= 0;
      minus_cnt <= 0;
      rise_cnt  <= 0;
      skew_cnt  <= 0;
    end
    else if (rclk_out && !rclk_q)
    begin
      rise_cnt  <= rise_cnt + 1;
      plus_cnt  <= plus_cnt + int'(plus_rail);
      minus_cnt <= minus_cnt + int'(minus_rail);
    end
    else if ({plus_rail, minus_rail} != rails_q)
      skew_cnt <= skew_cnt + 1;
  end
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for one receive output and drive monitor channel
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk, rstn, cyc, stb, we, ack, lp, lm, rclk, refc, txc, op, om, mp, mn;
  logic        rp, rm, rco, fault, los, lol, irq;
  logic [3:0]  adr, sel, wsel;
  logic [31:0] dat_i, dat_o, q;
  logic [2:0]  ph;
  int          rc, ref_half, cycles, failures, checked, fp, fm, fr, fs, p0, m0;
  logic [1:0]  lq[$];
  logic [3:0]  mq[$];

  lrd_channel lrd_channel_inst (.MCLK(mclk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .LINE_IN_PLUS(lp), .LINE_IN_MINUS(lm), .RCLK_IN(rclk), .REF_CLK_IN(refc),
    .TX_CLK_IN(txc), .LINE_OUT_PLUS(op), .LINE_OUT_MINUS(om), .MONITOR_PLUS_IN(mp),
    .MONITOR_MINUS_IN(mn), .RX_PLUS_RAIL(rp), .RX_MINUS_RAIL_OR_VIOLATION(rm),
    .RECOVERED_CLOCK_OUT(rco), .DRIVE_FAULT_FLAG(fault), .SIGNAL_LOST_FLAG(los),
    .CLOCK_UNLOCKED_FLAG(lol), .IRQ(irq));
  lrd_framer_model lrd_framer_model_inst (.mclk(mclk), .rstn(rstn), .rclk_out(rco),
    .plus_rail(rp), .minus_rail(rm), .plus_cnt(fp), .minus_cnt(fm), .rise_cnt(fr),
    .skew_cnt(fs));

  // System clock, 40 ns
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Link, transmit and reference clocks; bits change at the fall, far from the sampling rise
  always @(posedge mclk)
  begin
    ph <= ph + 3'h1;
    rclk <= (ph == 3'h3) | (rclk & (ph != 3'h7));
    txc <= (ph == 3'h3) | (txc & (ph != 3'h7));
    rc <= (rc + 1 >= ref_half) ? 0 : rc + 1;
    if (rc + 1 >= ref_half)
      refc <= ~refc;
    if (ph == 3'h7)
    begin
      {lp, lm} <= (lq.size() > 0) ? lq.pop_front() : 2'b00;
      {mp, mn, op, om} <= (mq.size() > 0) ? mq.pop_front() : 4'h0;
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failures++;
      summarize();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Classic single cycle; request held until ack is sampled
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= a;
    dat_i <= d;
    @(posedge mclk);
    while (ack !== 1'b1)
      @(posedge mclk);
    q = dat_o;
    chk(32'(ack), 32'h1, "bus ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task bits(input int n);
    repeat (n * 8) @(posedge mclk);
  endtask

  task drain;
    while (lq.size() > 0 || mq.size() > 0) @(posedge mclk);
  endtask

  task t_reset;
    chk(32'({rp, rm, rco, fault, los, lol, irq}), 32'h0, "outputs after reset");
    wb(1'b0, lrd_pkg::CTRL_OFS, 32'h0);
    chk(q, 32'(lrd_pkg::CTRL_RESET), "ctrl reset value");
    wb(1'b0, lrd_pkg::INT_MASK_OFS, 32'h0);
    chk(q, 32'(lrd_pkg::MASK_RESET), "mask reset value");
    wsel = 4'he;
    wb(1'b1, lrd_pkg::CTRL_OFS, 32'h1f);
    wsel = 4'hf;
    wb(1'b0, lrd_pkg::CTRL_OFS, 32'h0);
    chk(q, 32'(lrd_pkg::CTRL_RESET), "low lane off ignored");
    wb(1'b1, 4'h2, 32'hff);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0, "unmapped read");
  endtask

  task t_dual;
    p0 = fp;
    m0 = fm;
    lq = '{2'b10, 2'b10, 2'b01, 2'b00, 2'b10, 2'b01};
    drain;
    bits(3);
    chk(32'(fp - p0), 32'd3, "dual plus pulses");
    chk(32'(fm - m0), 32'd2, "dual minus pulses");
  endtask

  // Decoder off: a substitution-like pattern must pass untouched
  task t_single_raw;
    wb(1'b1, lrd_pkg::CTRL_OFS, 32'h1);
    p0 = fp;
    lq = '{2'b10, 2'b01, 2'b00, 2'b01};
    drain;
    bits(3);
    chk(32'(fp - p0), 32'd3, "single raw data");
  endtask

  task t_violation;
    wb(1'b1, lrd_pkg::CTRL_OFS, 32'h3);
    for (int i = 0; i < 40; i++)
      lq.push_back((i % 2 == 1 && i != 25) ? 2'b01 : 2'b10);
    bits(9);
    wb(1'b0, lrd_pkg::INT_STAT_OFS, 32'h0);
    m0 = fm;
    bits(12);
    chk(32'(fm - m0), 32'd0, "strobe on clean code");
    bits(8);
    chk(32'(fm > m0), 32'd1, "strobe on violation");
    wb(1'b0, lrd_pkg::INT_STAT_OFS, 32'h0);
    chk(32'(q[lrd_pkg::EV_VIOL]), 32'h1, "violation event");
    drain;
  endtask

  task t_los;
    wb(1'b1, lrd_pkg::CTRL_OFS, 32'h2);
    lq.push_back(2'b10);
    drain;
    bits(1);
    chk(32'(los), 32'h0, "signal present");
    bits(172);
    chk(32'(los), 32'h0, "short zero run");
    bits(5);
    chk(32'(los), 32'h1, "signal lost");
    wb(1'b0, lrd_pkg::STATUS_OFS, 32'h0);
    chk(32'(q[lrd_pkg::EV_LOS]), 32'h1, "status loss");
    // The bit that ends the loss still arrives inside it, so it stays muted
    wb(1'b1, lrd_pkg::CTRL_OFS, 32'h12);
    p0 = fp;
    lq = '{2'b10, 2'b10};
    drain;
    bits(3);
    chk(32'(fp - p0), 32'd1, "muted while lost");
  endtask

  // HDB3 substitution 000V is removed from single-rail data and raises no strobe
  task t_hdb3;
    wb(1'b1, lrd_pkg::CTRL_OFS, 32'h7);
    bits(4);
    p0 = fp;
    m0 = fm;
    lq = '{2'b01, 2'b10, 2'b00, 2'b00, 2'b00, 2'b10};
    drain;
    bits(3);
    chk(32'(fp - p0), 32'd2, "substitution removed");
    chk(32'(fm - m0), 32'd0, "no strobe on substitution");
  endtask

  // Fault interrupt raised, cleared by read, raised again, then masked
  task t_drive;
    wb(1'b1, lrd_pkg::INT_MASK_OFS, 32'h4);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h1, "irq raised");
    wb(1'b0, lrd_pkg::INT_STAT_OFS, 32'h0);
    chk(32'(q[lrd_pkg::EV_FAULT]), 32'h1, "fault event");
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0, "irq cleared");
    mq.push_back(4'h8);
    drain;
    bits(2);
    chk(32'(fault), 32'h0, "pulse clears fault");
    bits(125);
    chk(32'(fault), 32'h0, "quiet below limit");
    bits(4);
    chk(32'(fault), 32'h1, "quiet limit reached");
    chk(32'(irq), 32'h1, "irq raised again");
    wb(1'b1, lrd_pkg::INT_MASK_OFS, 32'h0);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0, "irq masked");
  endtask

  task t_int_mon;
    wb(1'b1, lrd_pkg::CTRL_OFS, 32'ha);
    mq.push_back(4'h1);
    drain;
    bits(2);
    chk(32'(fault), 32'h0, "internal pulse seen");
    for (int i = 0; i < 140; i++)
      mq.push_back((i % 2 == 1) ? 4'h4 : 4'h8);
    drain;
    chk(32'(fault), 32'h1, "external pins ignored");
    wb(1'b1, lrd_pkg::CTRL_OFS, 32'h2);
  endtask

  task t_lock;
    bits(1000);
    chk(32'(lol), 32'h0, "equal rates locked");
    ref_half = 3;
    bits(1600);
    chk(32'(lol), 32'h1, "rates apart unlocked");
    wb(1'b0, lrd_pkg::STATUS_OFS, 32'h0);
    chk(32'(q[lrd_pkg::EV_LOL]), 32'h1, "status unlocked");
    ref_half = 4;
    bits(2100);
    chk(32'(lol), 32'h0, "relocked");
  endtask

  task summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {rstn, cyc, stb, we, lp, lm, rclk, refc, txc, op, om, mp, mn} = 13'h0;
    adr = 4'h0;
    sel = 4'hf;
    wsel = 4'hf;
    dat_i = 32'h0;
    ph = 3'h0;
    ref_half = 4;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_dual();
    t_single_raw();
    t_violation();
    t_los();
    t_hdb3();
    t_drive();
    t_int_mon();
    t_lock();
    chk(32'(fs), 32'd0, "rails moved off clock rise");
    chk(32'(fr > 4000), 32'd1, "recovered clock runs");
    summarize();
  end
endmodule
`default_nettype wire
